// ---- core/iop_level_mem.sv ----
// Sink-level store: one 4-bit strength code per sink pin.
// Assumes writes come from the I/O write strobe on the core clock.
`timescale 1ns/1ps
module iop_level_mem (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write port.
  input wire logic wr_in,
  input wire logic [2:0] idx_in,
  input wire logic [3:0] data_in,
  // All levels, registered.
  output logic [31:0] levels_out
);
  genvar g;
  generate
    for (g = 0; g < iop_pkg::NSINK; g++) begin : g_lvl
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          levels_out[g*iop_pkg::LVL_W +: iop_pkg::LVL_W] <= iop_pkg::LVL_RST;
        end else if (wr_in && idx_in == 3'(g)) begin
          levels_out[g*iop_pkg::LVL_W +: iop_pkg::LVL_W] <= data_in;
        end
      end
    end
  endgenerate
endmodule

// ---- core/iop_ports.sv ----
// General-purpose ports, current-sink port and suspend/wake sequencing.
// Assumes the core drives the I/O strobes on clk_in and that clk_in keeps running.
`timescale 1ns/1ps
// Operation
// RULE1: Suspend bit write enters suspend.
// RULE2: Suspend stops oscillator, PLL, timer, watchdog, core.
// RULE3: Only enabled pin or bus activity wakes.
// RULE4: Firmware keeps run bit set to resume.
// RULE5: Oscillator restarts; run 1 ms after stable.
// RULE6: Next instruction runs before any interrupt.
// RULE7: Thirty-one pins over four ports.
// RULE8: Per-port pull-up input, open-drain or push-pull.
// RULE9: Port data registers reset to ones.
// RULE10: Firmware zeroes unused open-drain bits.
// RULE11: Firmware zeroes unbonded port three bits.
// RULE12: Normal reads return present pin levels.
// RULE13: Host-mode reads return latched host data.
// RULE14: Reset leaves all pins high impedance.
// RULE15: Writing zero drives the pin low.
// RULE16: Sink bit one pulls up, zero sinks.
// RULE17: Per-pin sink level from sixteen values.
// RULE18: Suspend bit disables the current sinks.
// RULE19: Firmware loads sink port ones before suspend.
// RULE20: Sink data at 0x30, resets ones.
// RULE21: Reserved port three bit never drives.
module iop_ports #(
  parameter int SETTLE_CYC = iop_pkg::SETTLE_CYC
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Internal I/O bus.
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [7:0] io_rdata_out,
  // General-purpose pins.
  input wire logic [31:0] gpio_pin_in,
  output logic [31:0] gpio_drive_out,
  output logic [31:0] gpio_oe_out,
  output logic [31:0] gpio_pullup_out,
  // Parallel host latched data for ports 0, 1 and 3.
  input wire logic [23:0] host_latch_in,
  // Current-sink port.
  input wire logic [7:0] sink_pin_in,
  output logic [7:0] sink_en_out,
  output logic [7:0] sink_pullup_out,
  output logic [31:0] sink_level_out,
  // Wake sources, clock status and instruction retire.
  input wire logic usb_activity_in,
  input wire logic osc_stable_in,
  input wire logic instr_retire_in,
  // Power and core control.
  output logic osc_en_out,
  output logic pll_en_out,
  output logic timer_en_out,
  output logic watchdog_counter_en_out,
  output logic core_en_out,
  output logic suspended_out,
  output logic irq_hold_out
);
  function automatic logic host_on(input logic [1:0] w, input int p);
    host_on = (p == 0 && w != 2'h0) || (p == 1 && (w == iop_pkg::HW_16 || w == iop_pkg::HW_24))
              || (p == 3 && w == iop_pkg::HW_24);
  endfunction

  // Pin synchronisers: a change is taken once the second and third stages agree.
  logic [41:0] s1_q, s2_q, s3_q, filt_q;
  wire [41:0] async_w = {usb_activity_in, osc_stable_in, sink_pin_in, gpio_pin_in};
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= async_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end
  end
  wire [31:0] pin_w = filt_q[31:0];
  wire osc_ok_w = filt_q[40];
  wire usb_act_w = filt_q[41];

  // Registers.
  logic [31:0] port_q, ie_q;
  logic [7:0] mode_q, hcfg_q, sink_q, psc_q;
  iop_pkg::iop_state_t st_q, st_d;
  logic [14:0] cnt_q;
  logic hold_q;

  wire wr_mode_w = io_wr_in && io_addr_in == iop_pkg::A_MODE;
  wire wr_hcfg_w = io_wr_in && io_addr_in == iop_pkg::A_HCFG;
  wire wr_sink_w = io_wr_in && io_addr_in == iop_pkg::A_SINK;
  wire wr_psc_w = io_wr_in && io_addr_in == iop_pkg::A_PSC;
  wire wr_lvl_w = io_wr_in && io_addr_in[7:3] == iop_pkg::A_LVL[7:3];
  wire [1:0] hw_w = hcfg_q[1:0];
  wire susp_bit_w = psc_q[iop_pkg::PSC_SUSP];
  wire run_bit_w = psc_q[iop_pkg::PSC_RUN];
  wire pin_wake_w = |(ie_q & ~pin_w);
  wire wake_w = pin_wake_w || usb_act_w;
  localparam logic [14:0] CNT_LAST = 15'(SETTLE_CYC - 1);
  wire settle_done_w = cnt_q == CNT_LAST;

  genvar p, b;
  generate
    for (p = 0; p < iop_pkg::NPORT; p++) begin : g_port
      wire wr_d = io_wr_in && io_addr_in == iop_pkg::A_PORT0 + 8'(p);
      wire wr_e = io_wr_in && io_addr_in == iop_pkg::A_IE0 + 8'(p);
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          port_q[8*p +: 8] <= iop_pkg::PORT_RST; // RULE9
          ie_q[8*p +: 8] <= iop_pkg::IE_RST;
        end else begin
          if (wr_d) begin
            port_q[8*p +: 8] <= io_wdata_in;
          end
          if (wr_e) begin
            ie_q[8*p +: 8] <= io_wdata_in;
          end
        end
      end
    end
    // Pin drivers; the reset state is open-drain with ones, so nothing is driven.
    for (b = 0; b < iop_pkg::NPIN; b++) begin : g_pin // RULE7
      wire [1:0] md = mode_q[2*(b/8) +: 2];
      wire pp = md[1];
      wire resv = b == iop_pkg::RESV_PIN;
      assign gpio_oe_out[b] = !resv && (pp || (md == iop_pkg::MD_OD && !port_q[b])); // RULE8 RULE14 RULE15 RULE21
      assign gpio_drive_out[b] = !resv && pp && port_q[b]; // RULE8 RULE15
      assign gpio_pullup_out[b] = !resv && md == iop_pkg::MD_PU; // RULE8
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_q <= iop_pkg::MODE_RST;
      hcfg_q <= iop_pkg::HCFG_RST;
      sink_q <= iop_pkg::SINK_RST; // RULE20
    end else begin
      if (wr_mode_w) begin
        mode_q <= io_wdata_in;
      end
      if (wr_hcfg_w) begin
        hcfg_q <= io_wdata_in;
      end
      if (wr_sink_w) begin
        sink_q <= io_wdata_in; // RULE20
      end
    end
  end

  // Sink port: pull-up on one, current sink on zero, sinks off while suspend is set.
  assign sink_pullup_out = sink_q; // RULE16
  assign sink_en_out = ~sink_q & {8{!susp_bit_w}}; // RULE16 RULE18

  iop_level_mem u_lvl (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_lvl_w),
    .idx_in(io_addr_in[2:0]),
    .data_in(io_wdata_in[3:0]),
    .levels_out(sink_level_out)
  ); // RULE17

  // Read selection: pins normally, host latches where host mode owns the port.
  wire [7:0] rd0_w = host_on(hw_w, 0) ? host_latch_in[7:0] : pin_w[7:0]; // RULE12 RULE13
  wire [7:0] rd1_w = host_on(hw_w, 1) ? host_latch_in[15:8] : pin_w[15:8]; // RULE12 RULE13
  wire [7:0] rd3_w = host_on(hw_w, 3) ? host_latch_in[23:16] : pin_w[31:24]; // RULE12 RULE13
  logic [7:0] rd_w;
  always_comb begin
    unique case (io_addr_in)
      iop_pkg::A_PORT0: rd_w = rd0_w;
      iop_pkg::A_PORT0 + 8'h01: rd_w = rd1_w;
      iop_pkg::A_PORT0 + 8'h02: rd_w = pin_w[23:16]; // RULE12
      iop_pkg::A_PORT0 + 8'h03: rd_w = rd3_w;
      iop_pkg::A_IE0: rd_w = ie_q[7:0];
      iop_pkg::A_IE0 + 8'h01: rd_w = ie_q[15:8];
      iop_pkg::A_IE0 + 8'h02: rd_w = ie_q[23:16];
      iop_pkg::A_IE0 + 8'h03: rd_w = ie_q[31:24];
      iop_pkg::A_MODE: rd_w = mode_q;
      iop_pkg::A_HCFG: rd_w = hcfg_q;
      iop_pkg::A_SINK: rd_w = sink_q;
      iop_pkg::A_PSC: rd_w = psc_q;
      default: rd_w = iop_pkg::RD_NONE;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      io_rdata_out <= iop_pkg::RD_NONE;
    end else if (io_rd_in) begin
      io_rdata_out <= rd_w;
    end
  end

  // Suspend sequencing. Hardware clears the suspend bit as the wake begins.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      iop_pkg::ST_RUN: if (susp_bit_w) st_d = iop_pkg::ST_SUSP; // RULE1
      iop_pkg::ST_SUSP: if (wake_w) st_d = iop_pkg::ST_OSC; // RULE3
      iop_pkg::ST_OSC: if (osc_ok_w) st_d = iop_pkg::ST_SETTLE; // RULE5
      iop_pkg::ST_SETTLE: if (settle_done_w) st_d = run_bit_w ? iop_pkg::ST_RUN : iop_pkg::ST_HALT; // RULE4 RULE5
      iop_pkg::ST_HALT: st_d = iop_pkg::ST_HALT;
      default: st_d = iop_pkg::ST_RUN;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_q <= iop_pkg::ST_RUN;
      cnt_q <= '0;
      psc_q <= iop_pkg::PSC_RST;
      hold_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= (st_q == iop_pkg::ST_SETTLE) ? cnt_q + 15'h0001 : '0; // RULE5
      if (wr_psc_w) begin
        psc_q <= io_wdata_in; // RULE1
      end else if (st_q == iop_pkg::ST_SUSP && wake_w) begin
        psc_q[iop_pkg::PSC_SUSP] <= 1'b0;
      end
      // Holding interrupts until one instruction retires keeps the post-suspend order.
      if (st_q == iop_pkg::ST_RUN && susp_bit_w) begin
        hold_q <= 1'b1; // RULE6
      end else if (st_q == iop_pkg::ST_RUN && instr_retire_in) begin
        hold_q <= 1'b0; // RULE6
      end
    end
  end

  wire in_run_w = st_q == iop_pkg::ST_RUN;
  assign suspended_out = st_q == iop_pkg::ST_SUSP;
  assign osc_en_out = !suspended_out; // RULE2 RULE5
  assign pll_en_out = !suspended_out; // RULE2
  assign timer_en_out = in_run_w; // RULE2
  assign watchdog_counter_en_out = in_run_w; // RULE2
  assign core_en_out = in_run_w; // RULE2
  assign irq_hold_out = hold_q; // RULE6

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_susp_entry: assert property (in_run_w && susp_bit_w |=> suspended_out) // RULE1
    else $error("suspend bit did not enter suspend");
  chk_susp_clocks: assert property (suspended_out |-> !osc_en_out && !pll_en_out && !timer_en_out
    && !watchdog_counter_en_out && !core_en_out) // RULE2
    else $error("clock or logic left running in suspend");
  chk_wake_cause: assert property (suspended_out && !wake_w |=> suspended_out) // RULE3
    else $error("woke without a wake source");
  chk_wake_osc: assert property (suspended_out && wake_w |=> osc_en_out && st_q == iop_pkg::ST_OSC) // RULE5
    else $error("oscillator not restarted on wake");
  chk_settle_hold: assert property (st_q == iop_pkg::ST_SETTLE && !settle_done_w |=> !core_en_out) // RULE5
    else $error("core ran before settle time");
  chk_settle_end: assert property (st_q == iop_pkg::ST_SETTLE && settle_done_w |=>
    (core_en_out == $past(run_bit_w)) && (st_q == iop_pkg::ST_HALT) == !$past(run_bit_w)) // RULE4 RULE5
    else $error("wrong state after settle");
  chk_irq_hold: assert property ($fell(irq_hold_out) |-> $past(instr_retire_in && in_run_w)) // RULE6
    else $error("interrupt hold dropped without an instruction");
  chk_hold_susp: assert property (suspended_out |-> irq_hold_out) // RULE6
    else $error("interrupt hold missing in suspend");
  chk_reset_ones: assert property (!$past(rst_n_in) |-> port_q == {4{iop_pkg::PORT_RST}}
    && sink_q == iop_pkg::SINK_RST && gpio_oe_out == '0) // RULE9 RULE14 RULE20
    else $error("reset values wrong");
  chk_od_low: assert property (io_wr_in && io_addr_in == iop_pkg::A_PORT0 && !io_wdata_in[0]
    && mode_q[1:0] == iop_pkg::MD_OD && !wr_mode_w |=> gpio_oe_out[0] && !gpio_drive_out[0]) // RULE15
    else $error("zero write did not drive low");
  chk_pp_drive: assert property (mode_q[3:2] == iop_pkg::MD_PP |->
    gpio_oe_out[15:8] == 8'hFF && gpio_drive_out[15:8] == port_q[15:8]) // RULE8
    else $error("push-pull port not driven");
  chk_sink_gate: assert property (susp_bit_w |-> sink_en_out == 8'h00) // RULE18
    else $error("current sink active with suspend set");
  chk_sink_write: assert property (wr_sink_w |=> sink_pullup_out == $past(io_wdata_in)
    && (susp_bit_w || sink_en_out == ~$past(io_wdata_in))) // RULE16 RULE20
    else $error("sink port write not applied");
  chk_read_pin: assert property (io_rd_in && io_addr_in == iop_pkg::A_PORT0 + 8'h02
    |=> io_rdata_out == $past(pin_w[23:16])) // RULE12
    else $error("port read not from pins");
  chk_read_host: assert property (io_rd_in && io_addr_in == iop_pkg::A_PORT0 && hw_w != 2'h0
    |=> io_rdata_out == $past(host_latch_in[7:0])) // RULE13
    else $error("host-mode read not from latch");
  chk_resv_float: assert property (!gpio_oe_out[iop_pkg::RESV_PIN]) // RULE21
    else $error("reserved bit driven");

  cov_suspend: cover property (in_run_w && susp_bit_w ##1 suspended_out);
  cov_wake_pin: cover property (suspended_out && pin_wake_w);
  cov_wake_usb: cover property (suspended_out && usb_act_w);
  cov_resume: cover property (st_q == iop_pkg::ST_SETTLE ##1 in_run_w);
endmodule

// ---- include/iop_pkg.sv ----
// Constants, register map and state codes for the I/O ports and suspend control.
// Assumes a single 20 MHz core clock and the internal I/O read/write strobes.
package iop_pkg;
  // Clock rate and wake settle time.
  localparam int CLK_MHZ = 20;
  localparam int SETTLE_US = 1000;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int CNT_W = 15;

  // Widths.
  localparam int NPIN = 32;
  localparam int NPORT = 4;
  localparam int NSINK = 8;
  localparam int LVL_W = 4;
  localparam int NSYNC = 42;

  // I/O addresses.
  localparam logic [7:0] A_PORT0 = 8'h00;
  localparam logic [7:0] A_IE0 = 8'h04;
  localparam logic [7:0] A_MODE = 8'h08;
  localparam logic [7:0] A_HCFG = 8'h09;
  localparam logic [7:0] A_SINK = 8'h30;
  localparam logic [7:0] A_LVL = 8'h38;
  localparam logic [7:0] A_PSC = 8'hFF;

  // Reset values.
  localparam logic [7:0] PORT_RST = 8'hFF;
  localparam logic [7:0] SINK_RST = 8'hFF;
  localparam logic [7:0] IE_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] HCFG_RST = 8'h00;
  localparam logic [7:0] PSC_RST = 8'h01;
  localparam logic [3:0] LVL_RST = 4'h0;
  localparam logic [7:0] RD_NONE = 8'h00;

  // Field positions.
  localparam int PSC_RUN = 0;
  localparam int PSC_SUSP = 3;
  localparam int RESV_PIN = 31;

  // Per-port drive modes, two bits per port in the mode register.
  localparam logic [1:0] MD_OD = 2'h0;
  localparam logic [1:0] MD_PU = 2'h1;
  localparam logic [1:0] MD_PP = 2'h2;

  // Parallel host width codes.
  localparam logic [1:0] HW_8 = 2'h1;
  localparam logic [1:0] HW_16 = 2'h2;
  localparam logic [1:0] HW_24 = 2'h3;

  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_SUSP = 5'b00010,
    ST_OSC = 5'b00100,
    ST_SETTLE = 5'b01000,
    ST_HALT = 5'b10000
  } iop_state_t;
endpackage

// ---- verif/iop_pin_model.sv ----
// Board model: resolves GPIO and sink pin levels from the block's drives.
// Assumes the bench supplies any external overdrive per pin.
`timescale 1ns/1ps
module iop_pin_model (
  // Clock.
  input wire logic clk_in,
  // Drives from the block.
  input wire logic [31:0] drive_in,
  input wire logic [31:0] oe_in,
  input wire logic [31:0] pullup_in,
  input wire logic [7:0] sink_en_in,
  input wire logic [7:0] sink_pullup_in,
  // External overdrive from the bench.
  input wire logic [31:0] ext_en_in,
  input wire logic [31:0] ext_val_in,
  // Resolved pin levels.
  output logic [31:0] pin_out,
  output logic [7:0] sink_pin_out
);
  // An undriven pin toggles, so a floating pin never passes for a steady level.
  logic [31:0] float_q = 32'h55555555;
  always_ff @(posedge clk_in) begin
    float_q <= ~float_q;
  end
  assign pin_out = (ext_en_in & ext_val_in) | (~ext_en_in & ((oe_in & drive_in) |
    (~oe_in & pullup_in) | (~oe_in & ~pullup_in & float_q)));
  assign sink_pin_out = ~sink_en_in & (sink_pullup_in | float_q[7:0]);
endmodule

// ---- verif/tb_iop_ports.sv ----
// Self-checking bench for the I/O ports and suspend control.
// Assumes the board model resolves every pin; the settle count is shortened to 20.
`timescale 1ns/1ps
module tb_iop_ports;
  localparam int SET = 20;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, spin, sen, spu;
  logic wr = 1'b0, rd = 1'b0, usb = 1'b0, ostb = 1'b1, ret = 1'b0;
  logic [31:0] pin, drv, oe, pu, lvl;
  logic [31:0] ext_en = 32'h80000000, ext_val = 32'h00000000;
  logic [23:0] host = 24'hC3963C;
  logic osc, pll, tmr, wdg, core, susp, hold;
  int fail_count = 0, checks_done = 0;

  iop_ports #(.SETTLE_CYC(SET)) u_iop_ports (.clk_in(clk_in), .rst_n_in(rst_n_in), .io_addr_in(addr),
    .io_wdata_in(wdat), .io_wr_in(wr), .io_rd_in(rd), .io_rdata_out(rdat), .gpio_pin_in(pin),
    .gpio_drive_out(drv), .gpio_oe_out(oe), .gpio_pullup_out(pu), .host_latch_in(host),
    .sink_pin_in(spin), .sink_en_out(sen), .sink_pullup_out(spu), .sink_level_out(lvl),
    .usb_activity_in(usb), .osc_stable_in(ostb), .instr_retire_in(ret), .osc_en_out(osc),
    .pll_en_out(pll), .timer_en_out(tmr), .watchdog_counter_en_out(wdg), .core_en_out(core),
    .suspended_out(susp), .irq_hold_out(hold));
  iop_pin_model u_iop_pin_model (.clk_in(clk_in), .drive_in(drv), .oe_in(oe), .pullup_in(pu),
    .sink_en_in(sen), .sink_pullup_in(spu), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pin_out(pin), .sink_pin_out(spin));

  always #25 clk_in = ~clk_in;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wdat = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    chk(32'(rdat), 32'(exp));
  endtask

  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask

  task automatic t_reset;
    chk(oe, 32'h00000000);
    chk(32'({sen, spu}), 32'h000000FF);
    rdc(8'h30, 8'hFF);
    rdc(8'h77, 8'h00);
    rdc(8'hFF, 8'h01);
    fin("reset");
  endtask

  task automatic t_ports;
    wrr(8'h08, 8'hAA);
    chk(oe, 32'h7FFFFFFF);
    chk(32'(drv[30:0]), 32'h7FFFFFFF);
    wrr(8'h00, 8'h5A);
    wrr(8'h03, 8'h00);
    chk(32'({oe[31], drv[7:0]}), 32'h0000005A);
    repeat (5) @(negedge clk_in);
    rdc(8'h00, 8'h5A);
    ext_en = 32'h80000001;
    ext_val = 32'h00000001;
    repeat (5) @(negedge clk_in);
    rdc(8'h00, 8'h5B);
    ext_en = 32'h80000000;
    wrr(8'h08, 8'h04);
    wrr(8'h00, 8'h5A);
    chk(32'({oe[15:0], pu[15:8]}), 32'h0000A5FF);
    repeat (5) @(negedge clk_in);
    rdc(8'h01, 8'hFF);
    fin("ports");
  endtask

  task automatic t_host;
    int w;
    int p;
    logic [7:0] e;
    wrr(8'h08, 8'hAA);
    wrr(8'h00, 8'h11);
    wrr(8'h01, 8'h22);
    wrr(8'h03, 8'h33);
    repeat (5) @(negedge clk_in);
    for (w = 1; w < 4; w++) begin
      wrr(8'h09, 8'(w));
      for (p = 0; p < 4; p++) begin
        e = 8'(32'h33FF2211 >> (8 * p));
        if (p == 0 || (p == 1 && w > 1) || (p == 3 && w == 3)) begin
          e = 8'(host >> (8 * (p == 3 ? 2 : p)));
        end
        rdc(8'(p), e);
      end
    end
    wrr(8'h09, 8'h00);
    fin("host");
  endtask

  task automatic t_sink;
    int v;
    wrr(8'h30, 8'h0F);
    chk(32'({spu, sen}), 32'h00000FF0);
    rdc(8'h30, 8'h0F);
    for (v = 0; v < 16; v++) begin
      wrr(8'(8'h38 + v % 8), 8'(v));
      chk(32'(lvl[4 * (v % 8) +: 4]), 32'(v));
    end
    rdc(8'h38, 8'h00);
    fin("sink");
  endtask

  task automatic t_suspend(input bit by_pin);
    int n;
    ext_en = 32'h80000003;
    ext_val = 32'h00000003;
    wrr(8'h04, 8'h01);
    wrr(8'hFF, 8'h09);
    repeat (3) @(negedge clk_in);
    ostb = 1'b0;
    chk(32'({osc, pll, tmr, wdg, core, susp, hold}), 32'h00000003);
    chk(32'(sen), 32'h00000000);
    ext_val = 32'h00000001;
    repeat (10) @(negedge clk_in);
    chk(32'(susp), 32'h00000001);
    if (by_pin) begin
      ext_val = 32'h00000000;
    end else begin
      usb = 1'b1;
    end
    n = 0;
    while (osc !== 1'b1 && n < 10) begin
      @(negedge clk_in);
      n++;
    end
    chk(32'({osc, pll, core}), 32'h00000006);
    usb = 1'b0;
    ext_val = 32'h00000003;
    ostb = 1'b1;
    n = 0;
    while (core !== 1'b1 && n < SET + 20) begin
      @(negedge clk_in);
      n++;
    end
    chk(32'(n >= SET && n <= SET + 8), 32'h00000001);
    chk(32'({hold, sen}), 32'h000001F0);
    ret = 1'b1;
    @(negedge clk_in);
    ret = 1'b0;
    chk(32'(hold), 32'h00000000);
    rdc(8'hFF, 8'h01);
    ext_en = 32'h80000000;
    fin(by_pin ? "pin wake" : "bus wake");
  endtask

  // Suspending with the run bit clear must end in the halt state, which only a reset leaves.
  task automatic t_halt;
    wrr(8'h30, 8'hFF);
    wrr(8'hFF, 8'h08);
    repeat (3) @(negedge clk_in);
    chk(32'({susp, sen, spu}), 32'h000100FF);
    usb = 1'b1;
    repeat (6) @(negedge clk_in);
    usb = 1'b0;
    repeat (SET + 10) @(negedge clk_in);
    chk(32'({osc, core, susp, hold}), 32'h00000009);
    rst_n_in = 1'b0;
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk(32'({core, susp, hold}), 32'h00000004);
    t_reset;
    fin("halt");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset;
    t_ports;
    t_host;
    t_sink;
    t_suspend(1'b1);
    t_suspend(1'b0);
    t_halt;
    test_done;
  end

  // The tests need well under 2000 cycles, so this limit only trips on a hang.
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    test_done;
  end
endmodule
